// ### fmdm_pkg.sv
// Shared constants, opcodes and carrier types of the float multiply, divide and mask unit.
// How it works
// - Double product multiplies unrounded and writes the lower product half, maybe unnormalized.
// - Double product exponent is the plain exponent sum, 48 below the upper product.
// - Coefficients multiply as signed magnitudes into 96 bits; low half is the coefficient.
// - Both normalized and only 95 product bits: shift coefficient left, exponent minus one.
// - Not both normalized: no leading-bit search; double product takes the lowest 48 product bits, upper product the highest 48.
// - Zero exponents, unnormalized: 48-bit integer sign-extended to 60 bits, overflow unflagged.
// - Multiply and divide flag infinite operand patterns as an exit condition.
// - Multiply and divide flag indefinite operand patterns as an exit condition.
// - Mask reads no operands; six-bit width sets that many top bits to one.
// - Divide first by second, drop remainder; normalized inputs give a normalized quotient.
// - Exponents subtract with correction; trial subtraction builds 49 quotient bits, then packs 48.
// - Dividend coefficient at least twice the divisor: divide fault and indefinite result.
// - Unnormalized dividend still gives a correct quotient; unnormalized divisor is not guaranteed.
// - Rounded divide puts an alternating round pattern just below the dividend coefficient.
// - Pass opcodes do nothing; their trailing designators have no effect.
// - Upper product takes the high half of the 96-bit product.
package fmdm_pkg;

    localparam int WORD_W = 60;
    localparam int COEF_W = 48;
    localparam int PROD_W = 96;

    localparam logic [5:0] OP_FMUL_HI = 6'h20;
    localparam logic [5:0] OP_FMUL_DP = 6'h22;
    localparam logic [5:0] OP_MASK    = 6'h23;
    localparam logic [5:0] OP_FDIV    = 6'h24;
    localparam logic [5:0] OP_FDIV_RN = 6'h25;
    localparam logic [5:0] OP_PASS    = 6'h26;

    localparam logic signed [12:0] EXP_BIAS_POS = 13'sh0400;
    localparam logic signed [12:0] EXP_BIAS_NEG = 13'sh03FF;
    localparam logic signed [12:0] EXP_ZERO     = 13'sh0000;
    localparam logic signed [12:0] EXP_MAX      = 13'sh03FF;
    localparam logic signed [12:0] EXP_MIN      = 13'sh1C01;
    localparam logic signed [12:0] EXP_HALF     = 13'sh0030;
    localparam logic signed [12:0] EXP_ONE      = 13'sh0001;
    localparam logic signed [12:0] DIV_EXP_CORR = 13'sh002F;

    localparam logic [10:0] INF_FIELD    = 11'h7FF;
    localparam logic [11:0] INF_POS_TOP  = 12'h7FF;
    localparam logic [11:0] INF_NEG_TOP  = 12'h800;
    localparam logic [11:0] IND_POS_TOP  = 12'h3FF;
    localparam logic [11:0] IND_NEG_TOP  = 12'hC00;
    localparam logic [59:0] INDEF_WORD   = 60'h3FF_0000_0000_0000;
    localparam logic [59:0] ALL_ONES     = 60'hFFF_FFFF_FFFF_FFFF;
    localparam logic [47:0] ROUND_PAT    = 48'h5555_5555_5555;
    localparam logic [5:0]  DIV_STEPS    = 6'h31;

    typedef struct packed {
        logic        valid;
        logic [5:0]  opcode;
        logic [2:0]  dest;
        logic [2:0]  j;
        logic [2:0]  k;
        logic [59:0] opa;
        logic [59:0] opb;
    } fmdm_req_t;

    typedef struct packed {
        logic        valid;
        logic        wr_en;
        logic [2:0]  dest;
        logic [59:0] data;
        logic        exit_inf;
        logic        exit_indef;
        logic        div_fault;
    } fmdm_rsp_t;

    typedef struct packed {
        logic               sign;
        logic signed [12:0] exp;
        logic [47:0]        coef;
        logic               norm;
        logic               ezero;
    } fmdm_fp_t;

endpackage

// ### fmdm_mul.sv
// Registered 48 by 48 coefficient multiplier giving the full 96-bit product.
module fmdm_mul
    import fmdm_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic [47:0] a_i,
    input  wire logic [47:0] b_i,
    output logic             done_o,
    output logic [95:0]      prod_o
);

    logic        done_q;
    logic [95:0] prod_q;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            done_q <= 1'b0;
        else
            done_q <= start_i;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            prod_q <= '0;
        else if (start_i)
            prod_q <= 96'(a_i) * 96'(b_i);
    end

    assign done_o = done_q;
    assign prod_o = prod_q;

endmodule

// ### fmdm_div.sv
// Restoring divider producing a 49-bit quotient of the coefficients, one bit per cycle.
module fmdm_div
    import fmdm_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic [47:0] dividend_i,
    input  wire logic [47:0] divisor_i,
    input  wire logic [47:0] low_i,
    output logic             done_o,
    output logic [48:0]      quot_o
);

    logic [48:0] rem_q;
    logic [48:0] bits_q;
    logic [47:0] dvs_q;
    logic [48:0] quot_q;
    logic [5:0]  cnt_q;
    logic        done_q;
    logic [48:0] shifted;
    logic        fits;

    // Remainder stays below the divisor, so bit 48 of the shifted value never overflows.
    assign shifted = {rem_q[47:0], bits_q[48]};
    assign fits    = shifted >= {1'b0, dvs_q};

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            rem_q  <= '0;
            bits_q <= '0;
            dvs_q  <= '0;
            quot_q <= '0;
        end
        else if (start_i)
        begin
            rem_q  <= {2'b00, dividend_i[47:1]};
            bits_q <= {dividend_i[0], low_i};
            dvs_q  <= divisor_i;
            quot_q <= '0;
        end
        else if (cnt_q != 6'h00)
        begin
            rem_q  <= fits ? shifted - {1'b0, dvs_q} : shifted;
            bits_q <= {bits_q[47:0], 1'b0};
            quot_q <= {quot_q[47:0], fits};
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= cnt_q == 6'h01;
            if (start_i)
                cnt_q <= DIV_STEPS;
            else if (cnt_q != 6'h00)
                cnt_q <= cnt_q - 6'h01;
        end
    end

    assign done_o = done_q;
    assign quot_o = quot_q;

endmodule

// ### fmdm_unit.sv
// Top of the float multiply, divide, mask and pass functional unit.
module fmdm_unit
    import fmdm_pkg::*;
(
    input  wire logic               sys_clk_i,
    input  wire logic               rst_n_i,
    input  wire fmdm_pkg::fmdm_req_t req_i,
    output logic                    busy_o,
    output fmdm_pkg::fmdm_rsp_t     rsp_o
);

    import fmdm_pkg::*;

    typedef enum logic [1:0] {
        FMDM_IDLE,
        FMDM_MUL,
        FMDM_DIV
    } fmdm_state_t;

    fmdm_state_t state_q;
    logic [5:0]  op_q;
    logic [2:0]  dest_q;
    fmdm_fp_t    ua_q;
    fmdm_fp_t    ub_q;
    logic        ex_inf_q;
    logic        ex_ind_q;
    logic        busy_q;
    fmdm_rsp_t   rsp_q;

    fmdm_fp_t    ua;
    fmdm_fp_t    ub;
    logic        accept;
    logic        is_mul;
    logic        is_div;
    logic        is_pass;
    logic        fault;
    logic        mul_start;
    logic        div_start;
    logic        op_inf;
    logic        op_ind;
    logic [59:0] mask_word;
    logic        mul_done;
    logic [95:0] prod;
    logic        div_done;
    logic [48:0] quot;
    logic [59:0] mul_word;
    logic [59:0] div_word;

    // Negative words are the complement of the positive word; both exponent zeros unpack to 0.
    function automatic fmdm_fp_t fmdm_unpack(input logic [59:0] w);
        logic [59:0] m;
        fmdm_fp_t    f;
        m      = w[59] ? ~w : w;
        f.sign = w[59];
        f.exp  = m[58] ? $signed({2'b00, m[58:48]}) - EXP_BIAS_POS
                       : $signed({2'b00, m[58:48]}) - EXP_BIAS_NEG;
        f.coef  = m[47:0];
        f.norm  = m[47];
        f.ezero = f.exp == EXP_ZERO;
        return f;
    endfunction

    // Exponents beyond the field saturate to infinity above and to zero below.
    function automatic logic [59:0] fmdm_pack(input logic s, input logic signed [12:0] e,
                                              input logic [47:0] c);
        logic [59:0] w;
        logic [12:0] f;
        f = '0;
        if (e > EXP_MAX)
            w = {1'b0, INF_FIELD, 48'h0000_0000_0000};
        else if (e < EXP_MIN)
            w = '0;
        else
        begin
            f = (e >= EXP_ZERO) ? e + EXP_BIAS_POS : e + EXP_BIAS_NEG;
            w = {1'b0, f[10:0], c};
        end
        return s ? ~w : w;
    endfunction

    function automatic logic fmdm_is_inf(input logic [59:0] w);
        return (w[59:48] == INF_POS_TOP) || (w[59:48] == INF_NEG_TOP);
    endfunction

    function automatic logic fmdm_is_ind(input logic [59:0] w);
        return (w[59:48] == IND_POS_TOP) || (w[59:48] == IND_NEG_TOP);
    endfunction

    assign ua        = fmdm_unpack(req_i.opa);
    assign ub        = fmdm_unpack(req_i.opb);
    assign accept    = req_i.valid && (state_q == FMDM_IDLE);
    assign is_mul    = (req_i.opcode == OP_FMUL_HI) || (req_i.opcode == OP_FMUL_DP);
    assign is_div    = (req_i.opcode == OP_FDIV) || (req_i.opcode == OP_FDIV_RN);
    // The pass group is picked by the destination field; j and k are never read for it.
    assign is_pass   = (req_i.opcode == OP_PASS) && !req_i.dest[2];
    assign fault     = {1'b0, ua.coef} >= {ub.coef, 1'b0};
    assign mul_start = accept && is_mul;
    assign div_start = accept && is_div && !fault;
    assign op_inf    = fmdm_is_inf(req_i.opa) || fmdm_is_inf(req_i.opb);
    assign op_ind    = fmdm_is_ind(req_i.opa) || fmdm_is_ind(req_i.opb);
    // Bit b is set when the width reaches down past it; widths of 60 and above give all ones.
    for (genvar b = 0; b < WORD_W; b++)
    begin : g_mask
        assign mask_word[b] = {req_i.j, req_i.k} > 6'(WORD_W - 1 - b);
    end

    fmdm_mul u_mul (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .start_i   (mul_start),
        .a_i       (ua.coef),
        .b_i       (ub.coef),
        .done_o    (mul_done),
        .prod_o    (prod)
    );

    // Divisor normalization is not checked; an unnormalized divisor gives an unspecified quotient.
    fmdm_div u_div (
        .sys_clk_i  (sys_clk_i),
        .rst_n_i    (rst_n_i),
        .start_i    (div_start),
        .dividend_i (ua.coef),
        .divisor_i  (ub.coef),
        .low_i      ((req_i.opcode == OP_FDIV_RN) ? ROUND_PAT : 48'h0000_0000_0000),
        .done_o     (div_done),
        .quot_o     (quot)
    );

    always_comb
    begin
        logic               sgn;
        logic               both_norm;
        logic               shift;
        logic signed [12:0] e;
        logic [47:0]        c;
        logic [59:0]        iw;
        sgn       = ua_q.sign ^ ub_q.sign;
        both_norm = ua_q.norm && ub_q.norm;
        shift     = both_norm && !prod[95];
        e         = ua_q.exp + ub_q.exp;
        c         = '0;
        iw        = {12'h000, prod[47:0]};
        if (op_q == OP_FMUL_HI)
        begin
            c = shift ? prod[94:47] : prod[95:48];
            e = e + EXP_HALF - (shift ? EXP_ONE : EXP_ZERO);
        end
        else if (shift)
        begin
            c = {prod[46:0], 1'b0};
            e = e - EXP_ONE;
        end
        else
            c = prod[47:0];
        if ((op_q == OP_FMUL_DP) && ua_q.ezero && ub_q.ezero && !ua_q.norm && !ub_q.norm)
            mul_word = sgn ? ~iw : iw;
        else
            mul_word = fmdm_pack(sgn, e, c);
    end

    // Quotient holds A*2^48/B; its top bit picks which 48 bits form the coefficient.
    always_comb
    begin
        logic signed [12:0] e;
        e = ua_q.exp - ub_q.exp - DIV_EXP_CORR;
        if (quot[48])
            div_word = fmdm_pack(ua_q.sign ^ ub_q.sign, e, quot[48:1]);
        else
            div_word = fmdm_pack(ua_q.sign ^ ub_q.sign, e - EXP_ONE, quot[47:0]);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            state_q <= FMDM_IDLE;
        else
        begin
            unique case (state_q)
                FMDM_IDLE:
                begin
                    if (mul_start)
                        state_q <= FMDM_MUL;
                    else if (div_start)
                        state_q <= FMDM_DIV;
                end
                FMDM_MUL:
                begin
                    if (mul_done)
                        state_q <= FMDM_IDLE;
                end
                FMDM_DIV:
                begin
                    if (div_done)
                        state_q <= FMDM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            op_q     <= '0;
            dest_q   <= '0;
            ua_q     <= '0;
            ub_q     <= '0;
            ex_inf_q <= 1'b0;
            ex_ind_q <= 1'b0;
        end
        else if (accept)
        begin
            op_q     <= req_i.opcode;
            dest_q   <= req_i.dest;
            ua_q     <= ua;
            ub_q     <= ub;
            ex_inf_q <= op_inf;
            ex_ind_q <= op_ind;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            busy_q <= 1'b0;
        else if (mul_start || div_start)
            busy_q <= 1'b1;
        else if (mul_done || div_done)
            busy_q <= 1'b0;
    end

    // The issuing side must drop valid after the taking edge, since a held request is taken again; nothing is queued here.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            rsp_q <= '0;
        else
        begin
            rsp_q.valid <= 1'b0;
            if (accept && !mul_start && !div_start)
            begin
                rsp_q.valid      <= 1'b1;
                rsp_q.dest       <= req_i.dest;
                rsp_q.wr_en      <= (req_i.opcode == OP_MASK) || is_div;
                rsp_q.data       <= (req_i.opcode == OP_MASK) ? mask_word : INDEF_WORD;
                rsp_q.exit_inf   <= is_div && op_inf;
                rsp_q.exit_indef <= is_div && op_ind;
                rsp_q.div_fault  <= is_div;
                if (is_pass)
                    rsp_q.wr_en <= 1'b0;
            end
            else if (mul_done || div_done)
            begin
                rsp_q.valid      <= 1'b1;
                rsp_q.dest       <= dest_q;
                rsp_q.wr_en      <= 1'b1;
                rsp_q.data       <= mul_done ? mul_word : div_word;
                rsp_q.exit_inf   <= ex_inf_q;
                rsp_q.exit_indef <= ex_ind_q;
                rsp_q.div_fault  <= 1'b0;
            end
        end
    end

    assign busy_o = busy_q;
    assign rsp_o  = rsp_q;

endmodule

// ### fmdm_unit_checker.sv
// Port-level assertions for the float multiply, divide and mask unit.
module fmdm_unit_checker
    import fmdm_pkg::*;
(
    input wire logic                sys_clk_i,
    input wire logic                rst_n_i,
    input wire fmdm_pkg::fmdm_req_t req_i,
    input wire logic                busy_o,
    input wire fmdm_pkg::fmdm_rsp_t rsp_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic        take;
    logic        mul;
    logic        dv;
    logic        flt;
    logic        inf;
    logic        ind;
    logic [47:0] ma;
    logic [47:0] mb;

    assign take = req_i.valid && !busy_o;
    assign mul  = req_i.opcode == OP_FMUL_HI || req_i.opcode == OP_FMUL_DP;
    assign dv   = req_i.opcode == OP_FDIV || req_i.opcode == OP_FDIV_RN;
    assign ma   = req_i.opa[59] ? ~req_i.opa[47:0] : req_i.opa[47:0];
    assign mb   = req_i.opb[59] ? ~req_i.opb[47:0] : req_i.opb[47:0];
    // Twice the divisor is formed in 49 bits so that it cannot wrap.
    assign flt  = {1'b0, ma} >= {mb, 1'b0};
    assign inf  = req_i.opa[59:48] inside {INF_POS_TOP, INF_NEG_TOP} ||
                  req_i.opb[59:48] inside {INF_POS_TOP, INF_NEG_TOP};
    assign ind  = req_i.opa[59:48] inside {IND_POS_TOP, IND_NEG_TOP} ||
                  req_i.opb[59:48] inside {IND_POS_TOP, IND_NEG_TOP};

    AST_MASK_DATA: assert property (take && req_i.opcode == OP_MASK |=>
        rsp_o.valid && rsp_o.wr_en && rsp_o.data == ~(ALL_ONES >> $past({req_i.j, req_i.k})))
        else $error("mask word wrong");
    AST_MASK_QUIET: assert property (take && req_i.opcode == OP_MASK |=>
        !rsp_o.exit_inf && !rsp_o.exit_indef && !rsp_o.div_fault)
        else $error("mask raised a flag");
    AST_MUL_LAT: assert property (take && mul |=> !rsp_o.valid && busy_o ##1 rsp_o.valid)
        else $error("multiply answer not after two cycles");
    AST_DIV_LAT: assert property (take && dv && !flt |=> busy_o ##50 (rsp_o.valid && !rsp_o.div_fault))
        else $error("divide answer not after 51 cycles");
    AST_DIV_FAULT: assert property (take && dv && flt |=>
        rsp_o.valid && rsp_o.div_fault && rsp_o.wr_en && rsp_o.data == INDEF_WORD)
        else $error("divide fault not reported");
    AST_PASS: assert property (take && req_i.opcode == OP_PASS && !req_i.dest[2] |=>
        rsp_o.valid && !rsp_o.wr_en)
        else $error("pass opcode wrote a result");
    AST_INF: assert property (take && (mul || dv) && inf |-> ##[1:51] (rsp_o.valid && rsp_o.exit_inf))
        else $error("infinite operand not flagged");
    AST_INDEF: assert property (take && (mul || dv) && ind |-> ##[1:51] (rsp_o.valid && rsp_o.exit_indef))
        else $error("indefinite operand not flagged");
    AST_BUSY_END: assert property ($fell(busy_o) |-> rsp_o.valid)
        else $error("busy dropped without a result");

    COV_DIV: cover property (take && dv && !flt);
    COV_FAULT: cover property (take && dv && flt);
    COV_MASK: cover property (take && req_i.opcode == OP_MASK);
endmodule

bind fmdm_unit fmdm_unit_checker u_chk (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .req_i     (req_i),
    .busy_o    (busy_o),
    .rsp_o     (rsp_o)
);

// ### fmdm_issuer.sv
// Behavioural model of the instruction issue logic that feeds the unit.
module fmdm_issuer
    import fmdm_pkg::*;
(
    input  wire logic                sys_clk_i,
    input  wire fmdm_pkg::fmdm_rsp_t rsp_i,
    output fmdm_pkg::fmdm_req_t      req_o
);
    initial req_o = '0;

    // Valid stands for the taking edge only, since holding it would issue the request again.
    task automatic send(input fmdm_req_t r, input int gap);
        int n;
        n = 0;
        repeat (gap) @(posedge sys_clk_i);
        req_o <= r;
        @(posedge sys_clk_i);
        // Released lines show the inverse so that a stale word cannot pass for a live one.
        req_o <= ~r;
        while (!rsp_i.valid && n < 60)
        begin
            n++;
            @(posedge sys_clk_i);
        end
    endtask
endmodule

// ### fmdm_unit_tb_top.sv
// Self-checking testbench of the float multiply, divide and mask unit.
module fmdm_unit_tb_top
    import fmdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic      sys_clk = 1'b0;
    logic      rst_n;
    logic      busy;
    fmdm_req_t req;
    fmdm_rsp_t rsp;
    fmdm_rsp_t em;
    fmdm_rsp_t mm;
    fmdm_rsp_t exp_q[$];
    fmdm_rsp_t msk_q[$];
    int        err_count = 0;
    int        n_checks = 0;
    int        cyc = 0;
    int        seed;

    always #10 sys_clk = ~sys_clk;

    fmdm_issuer issuer (.sys_clk_i(sys_clk), .rsp_i(rsp), .req_o(req));
    fmdm_unit uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .req_i(req), .busy_o(busy), .rsp_o(rsp));

    function automatic logic [47:0] r48();
        return 48'({$random(seed), $random(seed)});
    endfunction

    function automatic logic [59:0] pack(input logic s, input int e, input logic [47:0] c);
        logic [10:0] f;
        f = 11'(e >= 0 ? e + 1024 : e + 1023);
        return s ? ~{1'b0, f, c} : {1'b0, f, c};
    endfunction

    function automatic int xp(input logic [59:0] w);
        logic [10:0] f;
        f = w[59] ? ~w[58:48] : w[58:48];
        return f >= 11'h400 ? int'(f) - 1024 : int'(f) - 1023;
    endfunction

    function automatic fmdm_rsp_t ref_rsp(input fmdm_req_t r);
        fmdm_rsp_t   e;
        logic [47:0] ca;
        logic [47:0] cb;
        logic [95:0] p;
        logic [96:0] q;
        logic        s;
        logic        nz;
        logic        md;
        e = '0;
        e.valid = 1'b1;
        e.dest = r.dest;
        e.wr_en = r.opcode inside {OP_FMUL_HI, OP_FMUL_DP, OP_MASK, OP_FDIV, OP_FDIV_RN};
        md = e.wr_en && r.opcode != OP_MASK;
        ca = r.opa[59] ? ~r.opa[47:0] : r.opa[47:0];
        cb = r.opb[59] ? ~r.opb[47:0] : r.opb[47:0];
        s = r.opa[59] ^ r.opb[59];
        p = ca * cb;
        nz = ca[47] & cb[47] & ~p[95];
        e.exit_inf = md && (r.opa[59:48] inside {INF_POS_TOP, INF_NEG_TOP} ||
                            r.opb[59:48] inside {INF_POS_TOP, INF_NEG_TOP});
        e.exit_indef = md && (r.opa[59:48] inside {IND_POS_TOP, IND_NEG_TOP} ||
                              r.opb[59:48] inside {IND_POS_TOP, IND_NEG_TOP});
        case (r.opcode)
            OP_MASK:
                for (int b = 0; b < 60; b++)
                    e.data[59 - b] = b < int'({r.j, r.k});
            OP_FMUL_HI: e.data = pack(s, xp(r.opa) + xp(r.opb) + 48 - nz, nz ? p[94:47] : p[95:48]);
            OP_FMUL_DP:
                if (xp(r.opa) == 0 && xp(r.opb) == 0 && !ca[47] && !cb[47])
                    e.data = s ? ~{12'h000, p[47:0]} : {12'h000, p[47:0]};
                else
                    e.data = pack(s, xp(r.opa) + xp(r.opb) - nz, nz ? {p[46:0], 1'b0} : p[47:0]);
            OP_FDIV, OP_FDIV_RN:
            begin
                q = {1'b0, ca, 48'h000000000000} + (r.opcode == OP_FDIV_RN ? ROUND_PAT : 48'h000000000000);
                q = q / cb;
                if (q[48])
                    e.data = pack(s, xp(r.opa) - xp(r.opb) - 47, q[48:1]);
                else
                    e.data = pack(s, xp(r.opa) - xp(r.opb) - 48, q[47:0]);
                e.div_fault = {1'b0, ca} >= {cb, 1'b0};
                if (e.div_fault)
                    e.data = INDEF_WORD;
            end
            default: e.data = '0;
        endcase
        return e;
    endfunction

    task automatic go(input logic [5:0] op, input logic [5:0] jk, input logic [59:0] a, input logic [59:0] b,
                      input logic fo);
        fmdm_req_t r;
        fmdm_rsp_t m;
        fmdm_rsp_t e;
        r = {1'b1, op, 3'($random(seed)), jk, a, b};
        e = ref_rsp(r);
        m = '1;
        if (!e.wr_en)
            m.data = '0;
        // Results built from infinite or indefinite operands are judged on valid, write enable, destination and flags, not data.
        if (fo)
            m = {2'b11, 3'h7, 60'h0, 3'h7};
        exp_q.push_back(e);
        msk_q.push_back(m);
        issuer.send(r, $random(seed) & 1);
    endtask

    task automatic check(input fmdm_rsp_t seen, input fmdm_rsp_t exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        if (rst_n && rsp.valid && exp_q.size() == 0)
        begin
            err_count++;
            $display("wrong value at %0t: result with nothing expected", $time);
        end
        else if (rst_n && rsp.valid)
        begin
            em = exp_q.pop_front();
            mm = msk_q.pop_front();
            check(rsp & mm, em & mm);
        end
    end

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            err_count++;
            $display("wrong value at %0t: run did not finish", $time);
            wrap_up();
        end
    end

    initial
    begin
        logic [5:0]  ops [4];
        logic [11:0] tops [4];
        logic [47:0] ca;
        logic [47:0] cb;
        ops = '{OP_PASS, 6'h21, 6'h27, 6'h00};
        tops = '{INF_POS_TOP, INF_NEG_TOP, IND_POS_TOP, IND_NEG_TOP};
        seed = 32'h042a;
        rst_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int w = 0; w < 64; w++)
            go(OP_MASK, 6'(w), {r48(), 12'($random(seed))}, {r48(), 12'($random(seed))}, 1'b0);
        $display("mask test done");
        for (int i = 0; i < 16; i++)
            go(ops[i % 4], 6'($random(seed)), {r48(), 12'($random(seed))}, {r48(), 12'h000}, 1'b0);
        $display("pass test done");
        for (int i = 0; i < 16; i++)
            go(OP_FMUL_DP, 6'($random(seed)), pack(i[0], 0, {18'h0, 30'($random(seed))}),
               pack(i[1], 0, {18'h0, 30'($random(seed))}), 1'b0);
        $display("integer multiply test done");
        for (int i = 0; i < 32; i++)
        begin
            ca = r48() | {!i[1], 47'h0};
            cb = r48() | {!i[2], 47'h0};
            go(i[0] ? OP_FMUL_HI : OP_FMUL_DP, 6'($random(seed)), pack(i[3], $random(seed) % 100, ca),
               pack(i[4], $random(seed) % 100, cb), 1'b0);
        end
        $display("floating multiply test done");
        for (int i = 0; i < 24; i++)
        begin
            ca = r48() | {!i[1] | i[2], 47'h0};
            cb = i[2] ? r48() >> 2 : r48() | 48'h800000000000;
            go(i[0] ? OP_FDIV_RN : OP_FDIV, 6'($random(seed)), pack(i[3], $random(seed) % 100, ca),
               pack(i[4], $random(seed) % 100, cb), 1'b0);
        end
        $display("divide test done");
        for (int i = 0; i < 16; i++)
            go(i[0] ? (i[1] ? OP_FDIV_RN : OP_FDIV) : (i[1] ? OP_FMUL_HI : OP_FMUL_DP), 6'($random(seed)),
               {tops[i / 4], r48()}, pack(1'b0, 5, r48() | 48'h800000000000), 1'b1);
        $display("exit flag test done");
        repeat (3) @(posedge sys_clk);
        if (exp_q.size() != 0)
        begin
            err_count++;
            $display("wrong value at %0t: %0d results never arrived", $time, exp_q.size());
        end
        wrap_up();
    end
endmodule
